// [rtl/pcr_regs.svh]
/*
  Register offsets, field positions, reset values and level thresholds
  of the panel control and optical routing block.
  Assumes byte addressing on a 32-bit AHB-Lite bus, one word per register.
*/
`ifndef PCR_REGS_SVH
`define PCR_REGS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define PCR_OFS_CTRL 8'h00
`define PCR_OFS_STAT 8'h04
`define PCR_OFS_ISTAT 8'h08
`define PCR_OFS_IMASK 8'h0C

// ----------------------------------------------------------------------
// fields of control and status
// ----------------------------------------------------------------------
`define PCR_F_RATE 0
`define PCR_F_SYNC 4
`define PCR_F_O2A 8
`define PCR_F_FNV 9
`define PCR_F_INS 16
`define PCR_F_VOI 24

// interrupt status bits
`define PCR_EV_RATE 0
`define PCR_EV_SYNC 1
`define PCR_EV_MODE 2
`define PCR_EV_OVL 3

// ----------------------------------------------------------------------
// reset values and last rate index
// ----------------------------------------------------------------------
`define PCR_RATE_RST 3'h1
`define PCR_RATE_LAST 3'h5
`define PCR_IMASK_RST 4'h0

// ----------------------------------------------------------------------
// timing and level constants
// ----------------------------------------------------------------------
`define PCR_CLK_KHZ 125000
`define PCR_INT_FS_KHZ 48
`define PCR_INT_HALF (`PCR_CLK_KHZ / `PCR_INT_FS_KHZ / 2)
// meter thresholds as magnitude of a 24-bit full-scale sample
`define PCR_M42 24'h01_044A
`define PCR_M18 24'h10_1D4A
`define PCR_M12 24'h20_26F5
`define PCR_M6 24'h40_26E5
`define PCR_M3 24'h5A_9DF7
`define PCR_M0 24'h7F_FFFF

`endif

// [rtl/pcr_pkg.sv]
/*
  Types of the panel control and optical routing block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package pcr_pkg;

  typedef enum logic [2:0] {
    PCR_SYNC_INT = 3'b001,
    PCR_SYNC_OPT = 3'b010,
    PCR_SYNC_WORD = 3'b100
  } pcr_sync_t;

  typedef struct packed {
    logic [2:0] rate;
    pcr_sync_t sync;
    logic o2a;
    logic fn_voice;
    logic [7:0] ins_en;
    logic [7:0] voice_en;
    logic [3:0] istat;
    logic [3:0] imask;
    logic irq;
    logic [31:0] hrdata;
    logic hreadyout;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic nv_wr_en;
    logic [5:0] nv_wr_data;
    logic [5:0] rate_led;
    logic [2:0] sync_led;
    logic o2a_led;
    logic mst_g;
    logic mst_y;
    logic [7:0] ch_g;
    logic [7:0] ch_y;
    logic [7:0][23:0] line_out;
    logic [7:0][23:0] opt_r;
    logic [7:0][23:0] opt_l;
    logic [7:0][5:0] meter;
    logic [7:0] ovl;
    logic [15:0] int_cnt;
    logic int_clk;
    logic wclk_out;
    logic wc_lock;
  } pcr_state_t;

endpackage

`default_nettype wire

// [rtl/pcr_panel.sv]
/*
  Front-panel soft switches, settings storage hand-off, rate dependent
  optical channel mapping, metering, clock selection and AHB-Lite regs.
  Assumes buttons are one-cycle press pulses already debounced, audio
  words and clock levels synchronous to hclk, and an external store that
  answers nv_rd_valid once after power-up.
*/
// The implementer's own choices: the AHB-Lite register port and the address map.
// How it works
// - rate button steps six rates, one LED
// - rate saved to store, restored at power-up
// - sync button steps internal, optical, word clock
// - sync choice saved and restored
// - two master buttons pick insert or voicing
// - channel button toggles; green insert, yellow voicing
// - mode off: channels to line and optical
// - mode on: optical in to line, LED lit
// - mode setting saved and restored
// - optical outputs mapped by rate class
// - optical inputs demuxed with same mapping
// - optical input reaches only line outputs
// - meter segments at six dBFS levels
// - overload lamp from pre-insert level threshold
// - word clock out carries active sample clock
`include "pcr_regs.svh"
`default_nettype none

module pcr_panel
  import pcr_pkg::*;
#(
  parameter logic [23:0] OVL_THRESH = 24'h7F_0000,
  parameter int INT_HALF = `PCR_INT_HALF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  input wire logic btn_rate,
  input wire logic btn_sync,
  input wire logic btn_o2a,
  input wire logic btn_master_ins,
  input wire logic btn_master_voice,
  input wire logic [7:0] channel_function_button,
  input wire logic nv_rd_valid,
  input wire logic [5:0] nv_rd_data,
  output logic nv_wr_en,
  output logic [5:0] nv_wr_data,
  output logic [5:0] rate_led,
  output logic [2:0] sync_led,
  output logic o2a_led,
  output logic master_led_g,
  output logic master_led_y,
  output logic [7:0] ch_led_g,
  output logic [7:0] ch_led_y,
  output logic [7:0] insert_en,
  output logic [7:0] voicing_function,
  input wire logic samp_stb,
  input wire logic [7:0][23:0] ch_sample,
  input wire logic [7:0][23:0] pre_ins_sample,
  input wire logic [7:0][23:0] opt_in_r,
  input wire logic [7:0][23:0] opt_in_l,
  output logic [7:0][23:0] line_out,
  output logic [7:0][23:0] opt_out_r,
  output logic [7:0][23:0] opt_out_l,
  output logic [7:0][5:0] meter_seg,
  output logic [7:0] ovl_led,
  input wire logic wclk_in,
  input wire logic opt_clk_in,
  output logic wclk_out,
  output logic wc_lock_en
);

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  // 0 single, 1 double, 2 quad rate
  function automatic logic [1:0] rate_class(input logic [2:0] r);
    rate_class = (r < 3'h2) ? 2'd0 : ((r < 3'h4) ? 2'd1 : 2'd2);
  endfunction

  function automatic pcr_sync_t sync_dec(input logic [1:0] c);
    unique case (c)
      2'd1: sync_dec = PCR_SYNC_OPT;
      2'd2: sync_dec = PCR_SYNC_WORD;
      default: sync_dec = PCR_SYNC_INT;
    endcase
  endfunction

  function automatic logic [1:0] sync_enc(input pcr_sync_t s);
    unique case (s)
      PCR_SYNC_OPT: sync_enc = 2'd1;
      PCR_SYNC_WORD: sync_enc = 2'd2;
      default: sync_enc = 2'd0;
    endcase
  endfunction

  function automatic logic [23:0] mag(input logic [23:0] s);
    mag = s[23] ? (~s + 24'h00_0001) : s;
  endfunction

  pcr_state_t q, d;
  logic addr_ph;
  logic [3:0] ev;
  logic [3:0] clr;
  logic [1:0] rc;
  logic [23:0] m;

  assign addr_ph = hsel & htrans[1] & hready;

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb begin
    d = q;
    ev = 4'h0;
    clr = 4'h0;
    rc = 2'd0;
    m = 24'h00_0000;
    d.nv_wr_en = 1'b0;

    // panel buttons
    if (btn_rate) begin
      d.rate = (q.rate == `PCR_RATE_LAST) ? 3'h0 : q.rate + 3'h1;
    end
    if (btn_sync) begin
      unique case (q.sync)
        PCR_SYNC_INT: d.sync = PCR_SYNC_OPT;
        PCR_SYNC_OPT: d.sync = PCR_SYNC_WORD;
        default: d.sync = PCR_SYNC_INT;
      endcase
    end
    if (btn_o2a) begin
      d.o2a = ~q.o2a;
    end
    if (btn_master_ins) begin
      d.fn_voice = 1'b0;
    end else if (btn_master_voice) begin
      d.fn_voice = 1'b1;
    end
    if (q.fn_voice) begin
      d.voice_en = q.voice_en ^ channel_function_button;
    end else begin
      d.ins_en = q.ins_en ^ channel_function_button;
    end

    // bus write lands in the data phase
    if (q.wr_pend) begin
      unique case (q.wr_addr)
        `PCR_OFS_CTRL: begin
          if (hwdata[`PCR_F_RATE+:3] <= `PCR_RATE_LAST) begin
            d.rate = hwdata[`PCR_F_RATE+:3];
          end
          if (hwdata[`PCR_F_SYNC+:2] != 2'd3) begin
            d.sync = sync_dec(hwdata[`PCR_F_SYNC+:2]);
          end
          d.o2a = hwdata[`PCR_F_O2A];
          d.fn_voice = hwdata[`PCR_F_FNV];
        end
        `PCR_OFS_IMASK: d.imask = hwdata[3:0];
        default: ;
      endcase
    end

    // stored settings come back once after power-up
    if (nv_rd_valid) begin
      if (nv_rd_data[2:0] <= `PCR_RATE_LAST) begin
        d.rate = nv_rd_data[2:0];
      end
      if (nv_rd_data[4:3] != 2'd3) begin
        d.sync = sync_dec(nv_rd_data[4:3]);
      end
      d.o2a = nv_rd_data[5];
    end

    // any rate, sync or mode change is written back to the store, except in a cycle that loads from it
    ev[`PCR_EV_RATE] = d.rate != q.rate;
    ev[`PCR_EV_SYNC] = d.sync != q.sync;
    ev[`PCR_EV_MODE] = d.o2a != q.o2a;
    if (ev[2:0] != 3'h0 && !nv_rd_valid) begin
      d.nv_wr_en = 1'b1;
      d.nv_wr_data = {d.o2a, sync_enc(d.sync), d.rate};
    end

    // bus address phase; read data registered for the data phase
    d.wr_pend = addr_ph & hwrite;
    d.wr_addr = haddr[7:0];
    if (addr_ph && !hwrite) begin
      unique case (haddr[7:0])
        `PCR_OFS_CTRL: d.hrdata = {22'h00_0000, q.fn_voice, q.o2a,
                                   2'h0, sync_enc(q.sync), 1'b0, q.rate};
        `PCR_OFS_STAT: d.hrdata = {q.voice_en, q.ins_en, q.ovl,
                                   1'b0, q.wc_lock, q.sync_led, q.o2a_led,
                                   q.mst_y, q.mst_g};
        `PCR_OFS_ISTAT: begin
          d.hrdata = {28'h000_0000, q.istat};
          clr = q.istat;
        end
        `PCR_OFS_IMASK: d.hrdata = {28'h000_0000, q.imask};
        default: d.hrdata = 32'h0000_0000;
      endcase
    end
    d.hreadyout = 1'b1;

    // audio path
    rc = rate_class(q.rate);
    if (samp_stb) begin
      for (int i = 0; i < 8; i++) begin
        // optical out mapping
        unique case (rc)
          2'd0: begin
            d.opt_r[i] = ch_sample[i];
            d.opt_l[i] = ch_sample[i];
          end
          2'd1: begin
            d.opt_r[i] = (i < 4) ? ch_sample[i] : 24'h00_0000;
            // modulo keeps the unselected index inside the array
            d.opt_l[i] = (i < 4) ? ch_sample[(i + 4) % 8]
                                 : 24'h00_0000;
          end
          default: begin
            d.opt_r[i] = (i < 2) ? ch_sample[i] : 24'h00_0000;
            d.opt_l[i] = (i < 2) ? ch_sample[(i + 2) % 8]
                                 : 24'h00_0000;
          end
        endcase
        // line out: optical input is only ever taken here
        if (!q.o2a) begin
          d.line_out[i] = ch_sample[i];
        end else begin
          unique case (rc)
            2'd0: d.line_out[i] = opt_in_r[i];
            2'd1: d.line_out[i] = (i < 4) ? opt_in_r[i] :
                                  opt_in_l[(i + 4) % 8];
            default: d.line_out[i] = (i < 2) ? opt_in_r[i] :
                                  ((i < 4) ? opt_in_l[(i + 6) % 8]
                                  : 24'h00_0000);
          endcase
        end
        m = mag(ch_sample[i]);
        d.meter[i] = {m >= `PCR_M0, m >= `PCR_M3, m >= `PCR_M6,
                      m >= `PCR_M12, m >= `PCR_M18, m >= `PCR_M42};
        d.ovl[i] = mag(pre_ins_sample[i]) >= OVL_THRESH;
      end
    end
    ev[`PCR_EV_OVL] = (d.ovl & ~q.ovl) != 8'h00;

    // interrupts: set beats a read clear in the same cycle
    d.istat = (q.istat & ~clr) | ev;
    d.irq = |(d.istat & d.imask);

    // clocking
    if (q.int_cnt >= 16'(INT_HALF - 1)) begin
      d.int_cnt = 16'h0000;
      d.int_clk = ~q.int_clk;
    end else begin
      d.int_cnt = q.int_cnt + 16'h0001;
    end
    d.wc_lock = d.sync == PCR_SYNC_WORD;
    unique case (q.sync)
      PCR_SYNC_OPT: d.wclk_out = opt_clk_in;
      PCR_SYNC_WORD: d.wclk_out = wclk_in;
      default: d.wclk_out = q.int_clk;
    endcase

    // indicators follow the new settings
    d.rate_led = 6'h01 << d.rate;
    d.sync_led = d.sync;
    d.o2a_led = d.o2a;
    d.mst_g = ~d.fn_voice;
    d.mst_y = d.fn_voice;
    d.ch_g = d.ins_en;
    d.ch_y = d.voice_en;
  end

  // --------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.rate <= `PCR_RATE_RST;
      q.sync <= PCR_SYNC_INT;
      q.imask <= `PCR_IMASK_RST;
      q.rate_led <= 6'h02;
      q.sync_led <= PCR_SYNC_INT;
      q.mst_g <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign hrdata = q.hrdata;
  assign hreadyout = q.hreadyout;
  assign hresp = 1'b0;
  assign irq = q.irq;
  assign nv_wr_en = q.nv_wr_en;
  assign nv_wr_data = q.nv_wr_data;
  assign rate_led = q.rate_led;
  assign sync_led = q.sync_led;
  assign o2a_led = q.o2a_led;
  assign master_led_g = q.mst_g;
  assign master_led_y = q.mst_y;
  assign ch_led_g = q.ch_g;
  assign ch_led_y = q.ch_y;
  assign insert_en = q.ins_en;
  assign voicing_function = q.voice_en;
  assign line_out = q.line_out;
  assign opt_out_r = q.opt_r;
  assign opt_out_l = q.opt_l;
  assign meter_seg = q.meter;
  assign ovl_led = q.ovl;
  assign wclk_out = q.wclk_out;
  assign wc_lock_en = q.wc_lock;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  rate_step_a: assert property (btn_rate && !nv_rd_valid
    && !q.wr_pend |=> rate_led == ($past(q.rate) == 3'h5 ? 6'h01
                     : 6'h01 << ($past(q.rate) + 3'h1)))
    else $error("rate did not step");
  rate_onehot_a: assert property ($onehot(rate_led))
    else $error("rate leds not one-hot");
  sync_step_a: assert property (btn_sync
    && sync_led == PCR_SYNC_WORD && !nv_rd_valid && !q.wr_pend
    |=> sync_led == PCR_SYNC_INT)
    else $error("sync did not wrap");
  nv_store_a: assert property (btn_o2a && !nv_rd_valid
    && !q.wr_pend |=> nv_wr_en && nv_wr_data[5] == o2a_led)
    else $error("mode not stored");
  nv_load_a: assert property (nv_rd_valid
    && nv_rd_data[2:0] <= 3'h5
    |=> rate_led == 6'h01 << $past(nv_rd_data[2:0]))
    else $error("rate not restored");
  chan_toggle_a: assert property (master_led_g
    && !btn_master_voice && !q.wr_pend && channel_function_button[2]
    |=> ch_led_g[2] != $past(ch_led_g[2]))
    else $error("insert not toggled");
  line_src_a: assert property (samp_stb && !o2a_led
    |=> line_out[3] == $past(ch_sample[3]))
    else $error("line not fed by channel");
  opt_map_a: assert property (samp_stb && q.rate == 3'h3
    |=> opt_out_l[0] == $past(ch_sample[4])
        && opt_out_r[3] == $past(ch_sample[3]))
    else $error("double rate map wrong");
  demux_a: assert property (samp_stb && o2a_led && q.rate == 3'h5
    |=> line_out[2] == $past(opt_in_l[0]))
    else $error("quad rate demux wrong");
  wc_out_a: assert property (sync_led == PCR_SYNC_WORD
    |=> wclk_out == $past(wclk_in))
    else $error("word clock out not from input");
  wc_lock_a: assert property (wc_lock_en
    |-> sync_led == PCR_SYNC_WORD)
    else $error("locked to word clock wrongly");
  meter_red_a: assert property (samp_stb
    && ch_sample[0] == 24'h7F_FFFF |=> meter_seg[0] == 6'h3F)
    else $error("full scale not all segments");
  irq_a: assert property (q.imask[`PCR_EV_OVL]
    && (ovl_led & ~$past(ovl_led)) != 8'h00 |-> irq)
    else $error("overload irq missing");

  rate_wrap_c: cover property (btn_rate && rate_led == 6'h20);
  o2a_on_c: cover property (samp_stb && o2a_led);
  ovl_c: cover property (ovl_led != 8'h00);

endmodule

`default_nettype wire

// [tb/pcr_link_model.sv]
/*
  Far-side optical link partner: frames of 24-bit words on two ports,
  a frame strobe, a word clock and a link clock.
  Assumes the bench tells it the rate index chosen on the panel.
*/
`default_nettype none

module pcr_link_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [2:0] rate,
  output logic samp_stb,
  output logic [7:0][23:0] opt_r,
  output logic [7:0][23:0] opt_l,
  output logic wclk,
  output logic opt_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------------
  // frame generator
  // ------------------------------------------------------------------
  logic [3:0] cnt;
  logic [11:0] fr;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= '0;
      fr <= '0;
      samp_stb <= 1'b0;
      opt_r <= '0;
      opt_l <= '0;
      wclk <= 1'b0;
      opt_clk <= 1'b0;
    end else begin
      cnt <= cnt + 4'h1;
      samp_stb <= (cnt == 4'h0);
      wclk <= cnt[3];
      opt_clk <= cnt[2];
      if (cnt == 4'h0) begin
        fr <= fr + 12'h001;
        // slots a port does not carry at this rate toggle every frame
        for (int s = 0; s < 8; s++) begin
          if (rate < 3'h2 || s < (rate < 3'h4 ? 4 : 2))
            opt_r[s] <= {fr, 4'(s), 8'h5a};
          else
            opt_r[s] <= ~opt_r[s];
          if (rate >= 3'h2 && s < (rate < 3'h4 ? 4 : 2))
            opt_l[s] <= {fr, 4'(s + 8), 8'h3c};
          else
            opt_l[s] <= ~opt_l[s];
        end
      end
    end
  end
endmodule

`default_nettype wire

// [tb/testbench.sv]
/*
  Self-checking bench of the panel block: buttons, settings store,
  AHB-Lite registers, interrupt, routing, meters and clock choice.
  Assumes the link model on the optical side, INT_HALF shortened.
*/
`include "pcr_regs.svh"
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2, rate_cur = 3'h1, r;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, seed = 32'hf45d_ae06;
  logic hreadyout, hresp, irq, nv_wr_en, o2a_led, wclk_out, wc_lock_en;
  logic master_led_g, master_led_y, samp_stb, wclk_in, opt_clk_in, wp;
  logic nv_rd_valid = 0;
  logic [12:0] btn = '0;
  logic [5:0] nv_rd_data = '0, nv_wr_data, rate_led, nv_last = '0;
  logic [2:0] sync_led;
  logic [7:0] ch_led_g, ch_led_y, insert_en, voicing_function, ovl_led;
  logic [7:0][23:0] ch_sample = '0, pre_ins_sample = '0;
  logic [7:0][23:0] opt_in_r, opt_in_l, line_out, opt_out_r, opt_out_l;
  logic [7:0][5:0] meter_seg;
  int n_fail = 0, total_checks = 0, s, o;

  pcr_panel #(.INT_HALF(4)) dut_u (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .irq, .btn_rate(btn[0]), .btn_sync(btn[1]),
    .btn_o2a(btn[2]), .btn_master_ins(btn[3]),
    .btn_master_voice(btn[4]), .channel_function_button(btn[12:5]),
    .nv_rd_valid, .nv_rd_data, .nv_wr_en, .nv_wr_data, .rate_led,
    .sync_led, .o2a_led, .master_led_g, .master_led_y,
    .ch_led_g, .ch_led_y, .insert_en, .voicing_function, .samp_stb,
    .ch_sample, .pre_ins_sample, .opt_in_r, .opt_in_l, .line_out,
    .opt_out_r, .opt_out_l, .meter_seg, .ovl_led, .wclk_in,
    .opt_clk_in, .wclk_out, .wc_lock_en);

  pcr_link_model link_u (.hclk, .hresetn, .rate(rate_cur), .samp_stb,
    .opt_r(opt_in_r), .opt_l(opt_in_l), .wclk(wclk_in),
    .opt_clk(opt_clk_in));

  always #4 hclk = ~hclk;
  always @(posedge hclk) if (nv_wr_en === 1'b1) nv_last <= nv_wr_data;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return v[0] ? ((v >> 1) ^ 32'ha300_0000) : (v >> 1);
  endfunction
  function automatic logic [23:0] mag(input logic [23:0] v);
    return v[23] ? -v : v;
  endfunction
  function automatic logic [5:0] mseg(input logic [23:0] v);
    logic [23:0] m;
    m = mag(v);
    return {m >= `PCR_M0, m >= `PCR_M3, m >= `PCR_M6, m >= `PCR_M12,
      m >= `PCR_M18, m >= `PCR_M42};
  endfunction
  // port p: 0 right, 1 left
  function automatic logic [23:0] omap(input logic [2:0] q,
      input logic [7:0][23:0] c, input int p, input int i);
    if (q < 3'h2) return c[i];
    if (q < 3'h4) return (i < 4) ? c[i + 4 * p] : 24'h0;
    return (i < 2) ? c[i + 2 * p] : 24'h0;
  endfunction
  function automatic logic [23:0] lmap(input logic [2:0] q,
      input logic [7:0][23:0] a, input logic [7:0][23:0] b, input int i);
    if (q < 3'h2) return a[i];
    if (q < 3'h4) return (i < 4) ? a[i] : b[i - 4];
    if (i >= 4) return 24'h0;
    return (i < 2) ? a[i] : b[i - 2];
  endfunction

  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task press(input int b);
    btn <= 13'h0001 << b;
    @(posedge hclk);
    btn <= '0;
    repeat (3) @(posedge hclk);
  endtask
  // new words go in just after a frame edge, checked after the next
  task frame;
    do @(posedge hclk); while (samp_stb !== 1'b1);
    for (int i = 2; i < 8; i++) begin
      seed = lfsr(seed);
      ch_sample[i] <= seed[23:0] >> seed[27:24];
      seed = lfsr(seed);
      pre_ins_sample[i] <= seed[23:0];
    end
    ch_sample[0] <= `PCR_M0;
    ch_sample[1] <= `PCR_M42 - 24'h00_0001;
    pre_ins_sample[0] <= 24'h7f_0000;
    pre_ins_sample[1] <= 24'h7e_ffff;
    do @(posedge hclk); while (samp_stb !== 1'b1);
    repeat (3) @(posedge hclk);
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge hclk);
    chk({rate_led, sync_led, master_led_g}, {6'h02, 3'h1, 1'b1});
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    ahb(1'b0, `PCR_OFS_ISTAT, 32'h0);
    r = 3'h1;
    for (int i = 0; i < 6; i++) begin
      press(0);
      r = (r == 3'h5) ? 3'h0 : r + 3'h1;
      chk(rate_led, 6'h01 << r);
      chk(nv_last, {3'h0, r});
    end
    s = 0;
    for (int i = 0; i < 3; i++) begin
      press(1);
      s = (s + 1) % 3;
      chk(sync_led, 3'h1 << s);
      chk(wc_lock_en, s == 2);
      chk(nv_last, {1'b0, 2'(s), 3'h1});
      @(negedge hclk);
      wp = (s == 1) ? opt_clk_in : wclk_in;
      for (int j = 0; j < 20 && s != 0; j++) begin
        @(negedge hclk);
        chk(wclk_out, wp);
        wp = (s == 1) ? opt_clk_in : wclk_in;
      end
      @(posedge hclk);
    end
    press(2);
    chk({o2a_led, nv_last}, {1'b1, 6'h21});
    press(2);
    nv_rd_data <= 6'h2c;
    nv_rd_valid <= 1'b1;
    @(posedge hclk);
    nv_rd_valid <= 1'b0;
    repeat (2) @(posedge hclk);
    chk({rate_led, sync_led, o2a_led}, {6'h10, 3'h2, 1'b1});
    press(4);
    chk({master_led_g, master_led_y}, 2'b01);
    press(7);
    chk({voicing_function, ch_led_y}, 16'h0404);
    press(3);
    press(7);
    press(12);
    chk({master_led_g, insert_en, ch_led_g}, 17'h1_8484);
    ahb(1'b1, `PCR_OFS_IMASK, 32'h0000_0001);
    ahb(1'b0, `PCR_OFS_ISTAT, 32'h0);
    @(posedge hclk);
    chk(irq, 1'b0);
    press(0);
    chk(irq, 1'b1);
    ahb(1'b0, `PCR_OFS_ISTAT, 32'h0);
    chk(rd & 32'h1, 32'h1);
    repeat (2) @(posedge hclk);
    chk(irq, 1'b0);
    // only a new overload may raise the line from here on
    ahb(1'b1, `PCR_OFS_IMASK, 32'h0000_0008);
    press(0);
    chk(irq, 1'b0);
    ahb(1'b0, 32'h10, 32'h0);
    chk(rd, 32'h0);
    chk(hresp, 1'b0);
    for (o = 0; o < 2; o++) begin
      for (int k = 0; k < 3; k++) begin
        r = 3'(2 * k + 1);
        ahb(1'b1, `PCR_OFS_CTRL, {23'h0, 1'(o), 5'h0, r});
        rate_cur <= r;
        frame();
        frame();
        chk(o2a_led, o);
        for (int i = 0; i < 8; i++) begin
          chk(opt_out_r[i], omap(r, ch_sample, 0, i));
          chk(opt_out_l[i], omap(r, ch_sample, 1, i));
          chk(meter_seg[i], mseg(ch_sample[i]));
          chk(ovl_led[i], mag(pre_ins_sample[i]) >= 24'h7f_0000);
          if (o == 0)
            chk(line_out[i], ch_sample[i]);
          else
            chk(line_out[i], lmap(r, opt_in_r, opt_in_l, i));
        end
      end
    end
    chk(irq, 1'b1);
    ahb(1'b1, `PCR_OFS_CTRL, 32'h6);
    repeat (2) @(posedge hclk);
    chk(rate_led, 6'h20);
    results();
  end

  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    results();
  end
endmodule

`default_nettype wire
